// >>> hw/eppm_top.sv
// enhanced parallel port handshake engine with floppy port multiplexor, apb register slave
module eppm_top
	import eppm_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             iochrdy,
	output logic             zero_wait_out_n,
	input  wire logic        printer_not_floppy,
	input  wire logic [7:0]  fdc_out,
	output logic      [7:0]  fdd_out,
	input  wire logic [6:0]  fdd_in,
	output logic      [6:0]  fdc_in,
	input  wire logic [7:0]  pd_i,
	output logic      [7:0]  pd_o,
	output logic      [7:0]  pd_oe_n,
	input  wire logic [3:0]  ctl_pin_i,
	output logic      [3:0]  ctl_pin_o,
	output logic      [3:0]  ctl_pin_oe_n,
	input  wire logic [4:0]  stat_pin_i,
	output logic      [4:0]  stat_pin_o,
	output logic      [4:0]  stat_pin_oe_n
);
	// ********************************************************************
	// state
	// ********************************************************************
	typedef struct packed {
		eppm_state_e st;
		logic [7:0]  function_control_reg;
		logic [7:0]  opt;
		logic [7:0]  cfg;
		logic [7:0]  ctr;
		logic [7:0]  dtr;
		logic [7:0]  addr;
		logic [7:0]  data;
		logic [7:0]  pd_val;
		logic        use_addr;
		logic        is_wr;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        write_n;
		logic        astrb_n;
		logic        dstrb_n;
		logic        zws_n;
		logic        iochrdy;
		logic [7:0]  pd_o;
		logic [7:0]  pd_oe_n;
		logic [3:0]  ctl_o;
		logic [3:0]  ctl_oe_n;
		logic [4:0]  stat_o;
		logic [4:0]  stat_oe_n;
		logic [7:0]  fdd_out;
		logic [6:0]  fdc_in;
	} eppm_s;

	eppm_s      s_q;
	eppm_s      s_d;
	logic       wait_s;
	logic       floppy_mode;
	logic       epp_mode;
	logic       pd_drive;
	logic [7:0] mux_pd_o;
	logic [7:0] mux_pd_oe_n;
	logic [3:0] mux_ctl_o;
	logic [3:0] mux_ctl_oe_n;
	logic [4:0] mux_stat_o;
	logic [4:0] mux_stat_oe_n;
	logic [6:0] mux_fdc_in;

	// ********************************************************************
	// pin synchronisation and multiplexing
	// ********************************************************************
	eppm_sync #(
		.W (1)
	) u_wait_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.async_i (stat_pin_i[1]),
		.sync_o  (wait_s)
	);

	assign floppy_mode = s_q.function_control_reg[FCR_PPM_EN] & ~printer_not_floppy;
	assign epp_mode    = s_q.cfg[CFG_EPP];
	assign pd_drive    = ~s_q.ctr[CTR_DIR] & ~(s_q.st != EP_IDLE && !s_q.is_wr);

	eppm_mux u_mux (
		.float_pins  (s_q.function_control_reg[FCR_FLOAT]),
		.floppy_mode (floppy_mode),
		.epp_mode    (epp_mode),
		.ctl_bits    (s_q.ctr[3:0]),
		.write_n     (s_q.write_n),
		.astrb_n     (s_q.astrb_n),
		.dstrb_n     (s_q.dstrb_n),
		.pd_val      (epp_mode ? s_q.pd_val : s_q.dtr),
		.pd_drive    (pd_drive),
		.fdc_out     (fdc_out),
		.fdd_in      (fdd_in),
		.pd_i        (pd_i),
		.pd_o        (mux_pd_o),
		.pd_oe_n     (mux_pd_oe_n),
		.ctl_o       (mux_ctl_o),
		.ctl_oe_n    (mux_ctl_oe_n),
		.stat_o      (mux_stat_o),
		.stat_oe_n   (mux_stat_oe_n),
		.fdc_in      (mux_fdc_in)
	);

	// ********************************************************************
	// next state
	// ********************************************************************
	always_comb begin
		logic [3:0] idx;
		logic       acc;
		logic       is_epp;
		logic       bad;
		logic       launch;
		logic       zws_ok;
		logic [7:0] rd;
		logic [7:0] cap;

		s_d     = s_q;
		idx     = paddr[5:2];
		acc     = psel & penable & ~s_q.pready;
		is_epp  = (idx >= IDX_ADDR) && (idx <= IDX_DAT3);
		bad     = (paddr[1:0] != 2'b00) || (paddr[31:6] != 26'h0) || (idx > IDX_CFG);
		zws_ok  = s_q.function_control_reg[FCR_ZWS_EN] & ~s_q.function_control_reg[FCR_ZWS_OFF];
		// direction check applies only under software direction control
		launch  = epp_mode & ~(s_q.opt[OPT_CTL_DIR] & ~(s_q.ctr[CTR_DIR] ^ pwrite));
		cap     = s_q.use_addr ? s_q.addr : s_q.data;
		rd      = 8'h00;
		s_d.pready  = 1'b0;
		s_d.pslverr = 1'b0;
		s_d.prdata  = 32'h0000_0000;

		unique case (s_q.st)
			EP_IDLE: begin
				if (acc && bad) begin
					s_d.pready  = 1'b1;
					s_d.pslverr = 1'b1;
				end else if (acc && is_epp && launch) begin
					s_d.use_addr = (idx == IDX_ADDR);
					s_d.is_wr    = pwrite;
					if (pwrite) begin
						if (idx == IDX_ADDR) begin
							s_d.addr = pwdata[7:0];
						end else begin
							s_d.data = pwdata[7:0];
						end
					end
					if (pwrite && zws_ok) begin
						s_d.pd_val  = pwdata[7:0];
						s_d.write_n = 1'b0;
						s_d.st      = EP_ZW_STRB;
					end else begin
						s_d.iochrdy = 1'b0;
						s_d.st      = EP_WLOW;
					end
				end else if (acc) begin
					s_d.pready = 1'b1;
					if (pwrite) begin
						unique case (idx)
							IDX_DTR:  s_d.dtr = pwdata[7:0];
							IDX_CTR:  s_d.ctr = pwdata[7:0];
							IDX_ADDR: s_d.addr = pwdata[7:0];
							IDX_FCR:  s_d.function_control_reg = pwdata[7:0];
							IDX_OPT:  s_d.opt = pwdata[7:0];
							IDX_CFG:  s_d.cfg = pwdata[7:0];
							IDX_STR: begin
							end
							default:  s_d.data = pwdata[7:0];
						endcase
					end else begin
						unique case (idx)
							IDX_DTR:  rd = floppy_mode ? s_q.dtr : pd_i;
							IDX_STR: begin
								if (floppy_mode) begin
									rd = STS_FLOPPY;
								end else begin
									rd[STS_BUSY_N] = ~stat_pin_i[1];
									rd[STS_ACK]    = stat_pin_i[0];
									rd[STS_PE]     = stat_pin_i[2];
									rd[STS_SLCT]   = stat_pin_i[3];
									rd[STS_ERR]    = stat_pin_i[4];
								end
							end
							IDX_CTR:  rd = s_q.ctr;
							IDX_ADDR: rd = s_q.addr;
							IDX_FCR:  rd = s_q.function_control_reg;
							IDX_OPT:  rd = s_q.opt;
							IDX_CFG:  rd = s_q.cfg;
							default:  rd = s_q.data;
						endcase
						s_d.prdata = {24'h00_0000, rd};
					end
				end
			end
			EP_WLOW: begin
				if (!wait_s) begin
					if (s_q.is_wr) begin
						s_d.write_n = 1'b0;
						s_d.pd_val  = cap;
						s_d.st      = EP_STRB_ON;
					end else begin
						s_d.astrb_n = ~s_q.use_addr;
						s_d.dstrb_n = s_q.use_addr;
						s_d.st      = EP_STRB;
					end
				end
			end
			EP_STRB_ON: begin
				s_d.astrb_n = ~s_q.use_addr;
				s_d.dstrb_n = s_q.use_addr;
				s_d.st      = EP_STRB;
			end
			EP_STRB: begin
				if (wait_s) begin
					s_d.iochrdy = 1'b1;
					s_d.astrb_n = 1'b1;
					s_d.dstrb_n = 1'b1;
					s_d.pready  = 1'b1;
					if (s_q.is_wr) begin
						s_d.st = EP_TAIL;
					end else begin
						if (s_q.use_addr) begin
							s_d.addr = pd_i;
						end else begin
							s_d.data = pd_i;
						end
						s_d.prdata = {24'h00_0000, pd_i};
						s_d.st     = EP_IDLE;
					end
				end
			end
			EP_TAIL: begin
				if (acc && pwrite && is_epp && !bad && launch) begin
					// a pending write keeps WRITE low and starts straight away
					s_d.use_addr = (idx == IDX_ADDR);
					if (idx == IDX_ADDR) begin
						s_d.addr = pwdata[7:0];
					end else begin
						s_d.data = pwdata[7:0];
					end
					s_d.iochrdy = 1'b0;
					s_d.st      = EP_WLOW;
				end else if (!wait_s ||
						(s_q.opt[OPT_CTL_DIR] && s_q.ctr[CTR_DIR])) begin
					s_d.write_n = 1'b1;
					s_d.st      = EP_IDLE;
				end
			end
			EP_ZW_STRB: begin
				s_d.astrb_n = ~s_q.use_addr;
				s_d.dstrb_n = s_q.use_addr;
				s_d.st      = EP_ZW_CHK;
			end
			EP_ZW_CHK: begin
				if (wait_s) begin
					s_d.zws_n   = 1'b0;
					s_d.iochrdy = 1'b1;
					s_d.pready  = 1'b1;
					s_d.st      = EP_ZW_END;
				end else begin
					s_d.iochrdy = 1'b0;
					s_d.st      = EP_STRB;
				end
			end
			EP_ZW_END: begin
				s_d.astrb_n = 1'b1;
				s_d.dstrb_n = 1'b1;
				s_d.zws_n   = 1'b1;
				s_d.write_n = 1'b1;
				s_d.st      = EP_IDLE;
			end
		endcase

		// data lines only move while WRITE and both strobes are idle, or in EP_IDLE or EP_WLOW
		if (!(s_q.write_n && s_q.astrb_n && s_q.dstrb_n) &&
				!(s_q.st == EP_WLOW) && !(s_q.st == EP_IDLE)) begin
			s_d.pd_val = s_q.pd_val;
		end

		s_d.pd_o      = mux_pd_o;
		s_d.pd_oe_n   = mux_pd_oe_n;
		s_d.ctl_o     = mux_ctl_o;
		s_d.ctl_oe_n  = mux_ctl_oe_n;
		s_d.stat_o    = mux_stat_o;
		s_d.stat_oe_n = mux_stat_oe_n;
		s_d.fdc_in    = mux_fdc_in;
		s_d.fdd_out   = fdc_out;
	end

	// ********************************************************************
	// registers
	// ********************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q           <= '0;
			s_q.st        <= EP_IDLE;
			s_q.function_control_reg       <= FCR_RST;
			s_q.opt       <= OPT_RST;
			s_q.cfg       <= CFG_RST;
			s_q.ctr       <= CTR_RST;
			s_q.dtr       <= DTR_RST;
			s_q.write_n   <= 1'b1;
			s_q.astrb_n   <= 1'b1;
			s_q.dstrb_n   <= 1'b1;
			s_q.zws_n     <= 1'b1;
			s_q.iochrdy   <= 1'b1;
			s_q.pd_oe_n   <= 8'hFF;
			s_q.ctl_o     <= 4'hF;
			s_q.ctl_oe_n  <= 4'hF;
			s_q.stat_oe_n <= 5'h1F;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata          = s_q.prdata;
	assign pready          = s_q.pready;
	assign pslverr         = s_q.pslverr;
	assign iochrdy         = s_q.iochrdy;
	assign zero_wait_out_n = s_q.zws_n;
	assign fdd_out         = s_q.fdd_out;
	assign fdc_in          = s_q.fdc_in;
	assign pd_o            = s_q.pd_o;
	assign pd_oe_n         = s_q.pd_oe_n;
	assign ctl_pin_o       = s_q.ctl_o;
	assign ctl_pin_oe_n    = s_q.ctl_oe_n;
	assign stat_pin_o      = s_q.stat_o;
	assign stat_pin_oe_n   = s_q.stat_oe_n;
endmodule : eppm_top

// >>> hw/eppm_pkg.sv
// constants, register indices and state encoding of the epp handshake and port mux
package eppm_pkg;

	// ********************************************************************
	// register indices (byte address is four times the index)
	// ********************************************************************
	localparam logic [3:0] IDX_DTR  = 4'h0;
	localparam logic [3:0] IDX_STR  = 4'h1;
	localparam logic [3:0] IDX_CTR  = 4'h2;
	localparam logic [3:0] IDX_ADDR = 4'h3;
	localparam logic [3:0] IDX_DAT0 = 4'h4;
	localparam logic [3:0] IDX_DAT3 = 4'h7;
	localparam logic [3:0] IDX_FCR  = 4'h8;
	localparam logic [3:0] IDX_OPT  = 4'h9;
	localparam logic [3:0] IDX_CFG  = 4'hA;

	// ********************************************************************
	// field positions
	// ********************************************************************
	localparam int FCR_PPM_EN  = 2;
	localparam int FCR_FLOAT   = 3;
	localparam int FCR_ZWS_EN  = 5;
	localparam int FCR_ZWS_OFF = 6;
	localparam int OPT_CTL_DIR = 7;
	localparam int CTR_DIR     = 5;
	localparam int CFG_EPP     = 0;
	localparam int CFG_REV19   = 1;
	localparam int STS_BUSY_N  = 7;
	localparam int STS_ACK     = 6;
	localparam int STS_PE      = 5;
	localparam int STS_SLCT    = 4;
	localparam int STS_ERR     = 3;

	// ********************************************************************
	// reset and fixed values
	// ********************************************************************
	localparam logic [7:0] FCR_RST     = 8'h00;
	localparam logic [7:0] OPT_RST     = 8'h00;
	localparam logic [7:0] CFG_RST     = 8'h00;
	localparam logic [7:0] CTR_RST     = 8'h00;
	localparam logic [7:0] DTR_RST     = 8'h00;
	localparam logic [7:0] STS_FLOPPY  = 8'h48;

	typedef enum logic [2:0] {
		EP_IDLE,
		EP_WLOW,
		EP_STRB_ON,
		EP_STRB,
		EP_TAIL,
		EP_ZW_STRB,
		EP_ZW_CHK,
		EP_ZW_END
	} eppm_state_e;

endpackage : eppm_pkg

// >>> hw/eppm_sync.sv
// two flip-flop synchroniser for asynchronous level inputs
module eppm_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			sync_o <= '0;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule : eppm_sync

// >>> hw/eppm_mux.sv
// connector pin multiplexor between parallel port and floppy controller
module eppm_mux (
	input  wire logic       float_pins,
	input  wire logic       floppy_mode,
	input  wire logic       epp_mode,
	input  wire logic [3:0] ctl_bits,
	input  wire logic       write_n,
	input  wire logic       astrb_n,
	input  wire logic       dstrb_n,
	input  wire logic [7:0] pd_val,
	input  wire logic       pd_drive,
	input  wire logic [7:0] fdc_out,
	input  wire logic [6:0] fdd_in,
	input  wire logic [7:0] pd_i,
	output logic      [7:0] pd_o,
	output logic      [7:0] pd_oe_n,
	output logic      [3:0] ctl_o,
	output logic      [3:0] ctl_oe_n,
	output logic      [4:0] stat_o,
	output logic      [4:0] stat_oe_n,
	output logic      [6:0] fdc_in
);
	always_comb begin
		pd_o      = pd_val;
		pd_oe_n   = {8{~pd_drive}};
		stat_o    = 5'h00;
		stat_oe_n = 5'h1F;
		ctl_oe_n  = 4'h0;
		// pins: {select-in/astrb, init, autofeed/dstrb, strobe/write}
		if (epp_mode) begin
			ctl_o = {astrb_n, ctl_bits[2], dstrb_n, write_n};
		end else begin
			ctl_o = {~ctl_bits[3], ctl_bits[2], ~ctl_bits[1], ~ctl_bits[0]};
		end
		if (floppy_mode) begin
			// data pins become floppy inputs, handshake pins other than strobe floppy outputs
			pd_oe_n   = 8'hFF;
			stat_o    = {fdc_out[5], fdc_out[3], fdc_out[2], fdc_out[1], fdc_out[0]};
			stat_oe_n = 5'h00;
			ctl_o     = {fdc_out[7], fdc_out[6], fdc_out[4], 1'b1};
			ctl_oe_n  = 4'h1;
		end
		if (float_pins) begin
			pd_oe_n   = 8'hFF;
			ctl_oe_n  = 4'hF;
			stat_oe_n = 5'h1F;
		end
		// drive one selected on the connector takes inputs from the connector
		if (floppy_mode && !fdc_out[0]) begin
			fdc_in = {pd_i[7], pd_i[5], pd_i[4], pd_i[3], pd_i[2], pd_i[1], pd_i[0]};
		end else begin
			fdc_in = fdd_in;
		end
	end
endmodule : eppm_mux

// >>> dv/eppm_props.sv
// port assertions for the epp handshake and port mux
module eppm_props
	import eppm_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        iochrdy,
	input wire logic        zero_wait_out_n,
	input wire logic [7:0]  fdc_out,
	input wire logic [7:0]  fdd_out,
	input wire logic [7:0]  pd_o,
	input wire logic [7:0]  pd_oe_n,
	input wire logic [3:0]  ctl_pin_o,
	input wire logic [4:0]  stat_pin_i
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****
	// sequences
	// ****
	sequence s_strb_held;
		!ctl_pin_o[3] [*2];
	endsequence
	sequence s_zws_end;
		zero_wait_out_n;
	endsequence
	AST_WAIT_SYNC: assert property ($rose(stat_pin_i[1]) && !ctl_pin_o[3] |=> s_strb_held)
		else $error("strobe released too soon after wait rose");
	AST_ZWS_PULSE: assert property (!zero_wait_out_n |-> pready && iochrdy ##1 s_zws_end)
		else $error("zero wait output not a single completed cycle");
	AST_ZWS_STRETCH: assert property (!iochrdy |-> zero_wait_out_n)
		else $error("zero wait output low while host stretched");
	AST_PD_STABLE: assert property (!pd_oe_n[0] && $past(pd_oe_n[0]) == 1'b0
		&& !(ctl_pin_o[3] && ctl_pin_o[1]) && $past(ctl_pin_o[3] && ctl_pin_o[1]) == 1'b0
		|-> $stable(pd_o)) else $error("port data moved under a strobe");
	AST_WRITE_FIRST: assert property (($fell(ctl_pin_o[3]) || $fell(ctl_pin_o[1])) && psel
		&& pwrite |-> $past(ctl_pin_o[0]) == 1'b0) else $error("strobe before write");
	AST_READ_WRITE_HI: assert property ($fell(ctl_pin_o[3]) && psel && !pwrite |-> ctl_pin_o[0])
		else $error("write low during a read strobe");
	AST_BUS_FREE: assert property (!pready |-> prdata == 32'h0)
		else $error("read data driven outside the answer cycle");
	AST_FDD_OUT: assert property (fdd_out == $past(fdc_out))
		else $error("dedicated floppy pins do not follow the controller");
endmodule // eppm_props

bind eppm_top eppm_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .pwrite(pwrite),
	.pready(pready), .prdata(prdata), .iochrdy(iochrdy), .zero_wait_out_n(zero_wait_out_n),
	.fdc_out(fdc_out), .fdd_out(fdd_out), .pd_o(pd_o), .pd_oe_n(pd_oe_n),
	.ctl_pin_o(ctl_pin_o), .stat_pin_i(stat_pin_i));

// >>> dv/eppm_periph.sv
// behavioural epp peripheral on the connector side
module eppm_periph
	import eppm_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [3:0] ctl_o,
	input  wire logic [3:0] ctl_oe_n,
	input  wire logic [7:0] pd_pins,
	input  wire logic       hold_hi,
	input  wire logic [3:0] dly,
	input  wire logic [7:0] rd_byte,
	output logic            wait_n,
	output logic      [7:0] pd_drv,
	output logic      [7:0] cap_byte,
	output logic            cap_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	logic       strb;
	assign strb = !((ctl_o[3] | ctl_oe_n[3]) & (ctl_o[1] | ctl_oe_n[1]));
	// read byte only under a read strobe, the inverted read byte otherwise
	assign pd_drv = (strb && ctl_o[0]) ? rd_byte : ~rd_byte;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_n <= 1'b0;
			cnt <= 4'h0;
			cap_byte <= 8'h00;
			cap_addr <= 1'b0;
		end else begin
			if (strb && !ctl_o[0]) begin
				cap_byte <= pd_pins;
				cap_addr <= !ctl_o[3];
			end
			if (hold_hi) begin
				wait_n <= 1'b1;
			end else if (strb) begin
				cnt <= (cnt == dly) ? cnt : cnt + 4'h1;
				wait_n <= (cnt == dly);
			end else begin
				cnt <= 4'h0;
				wait_n <= 1'b0;
			end
		end
	end
endmodule // eppm_periph

// >>> dv/eppm_top_tb_top.sv
// self-checking bench of the epp handshake and port mux
module eppm_top_tb_top
	import eppm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, iochrdy, zero_wait_out_n;
	logic [31:0] paddr, pwdata, prdata;
	logic        printer_not_floppy, hold_hi, wait_n, cap_addr, use_tb_pd, r_err, r_zws, seen_low;
	logic [7:0]  fdc_out, fdd_out, pd_i, pd_o, pd_oe_n, rd_byte, m_pd, cap_byte, tb_pd, r_data;
	logic [6:0]  fdd_in, fdc_in;
	logic [3:0]  ctl_pin_i, ctl_pin_o, ctl_pin_oe_n, dly;
	logic [4:0]  stat_pin_i, stat_pin_o, stat_pin_oe_n;
	int          err_count, compares;
	assign pd_i = (~pd_oe_n & pd_o) | (pd_oe_n & (use_tb_pd ? tb_pd : m_pd));
	assign ctl_pin_i = (~ctl_pin_oe_n & ctl_pin_o) | ctl_pin_oe_n;
	assign stat_pin_i = (~stat_pin_oe_n & stat_pin_o) | (stat_pin_oe_n & {3'b110, wait_n, 1'b1});
	eppm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.iochrdy(iochrdy), .zero_wait_out_n(zero_wait_out_n), .printer_not_floppy(printer_not_floppy),
		.fdc_out(fdc_out), .fdd_out(fdd_out), .fdd_in(fdd_in), .fdc_in(fdc_in), .pd_i(pd_i),
		.pd_o(pd_o), .pd_oe_n(pd_oe_n), .ctl_pin_i(ctl_pin_i), .ctl_pin_o(ctl_pin_o),
		.ctl_pin_oe_n(ctl_pin_oe_n), .stat_pin_i(stat_pin_i), .stat_pin_o(stat_pin_o),
		.stat_pin_oe_n(stat_pin_oe_n));
	eppm_periph u_periph (.pclk(pclk), .presetn(presetn), .ctl_o(ctl_pin_o), .ctl_oe_n(ctl_pin_oe_n),
		.pd_pins(pd_i), .hold_hi(hold_hi), .dly(dly), .rd_byte(rd_byte), .wait_n(wait_n),
		.pd_drv(m_pd), .cap_byte(cap_byte), .cap_addr(cap_addr));
	always @(posedge pclk) if (iochrdy === 1'b0) seen_low <= 1'b1;
	// ****
	// helpers
	// ****
	task automatic stop_test();
		if (err_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {26'h0, idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 500);
		if (n >= 500) err_count++;
		r_data = prdata[7:0];
		r_err = pslverr;
		r_zws = zero_wait_out_n;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_zws();
		hold_hi <= 1'b1;
		apb(1, IDX_CFG, 8'h01);
		apb(1, IDX_FCR, 8'h20);
		apb(1, IDX_ADDR, 8'h5A);
		chk(r_zws, 0);
		chk({cap_addr, cap_byte}, 9'h15A);
		apb(1, IDX_DAT0, 8'hA5);
		chk(r_zws, 0);
		chk({cap_addr, cap_byte}, 9'h0A5);
		apb(1, IDX_FCR, 8'h60);
		seen_low = 1'b0;
		fork
			apb(1, IDX_ADDR, 8'h11);
			begin repeat (8) @(posedge pclk); hold_hi <= 1'b0; end
		join
		chk({r_zws, seen_low}, 2'b11);
		apb(1, IDX_FCR, 8'h20);
		dly <= 4'h6;
		seen_low = 1'b0;
		apb(1, IDX_DAT0, 8'h3C);
		chk({r_zws, seen_low, cap_byte}, 10'h33C);
	endtask
	task automatic t_rev19();
		apb(1, IDX_FCR, 8'h00);
		apb(1, IDX_CFG, 8'h03);
		dly <= 4'h3;
		seen_low = 1'b0;
		apb(1, IDX_ADDR, 8'h33);
		chk({seen_low, cap_addr, cap_byte}, 10'h333);
		apb(1, IDX_DAT0, 8'h44);
		chk({cap_addr, cap_byte}, 9'h044);
		rd_byte <= 8'hC3;
		apb(0, IDX_ADDR, 8'h00);
		chk(r_data, 8'hC3);
		rd_byte <= 8'h3C;
		apb(0, IDX_DAT3, 8'h00);
		chk(r_data, 8'h3C);
		chk(prdata, 0);
		apb(1, IDX_OPT, 8'h80);
		apb(1, IDX_CTR, 8'h20);
		apb(1, IDX_DAT0, 8'h77);
		chk(cap_byte, 8'h44);
		apb(1, IDX_CTR, 8'h00);
		apb(1, IDX_OPT, 8'h00);
	endtask
	task automatic t_floppy();
		apb(1, IDX_CFG, 8'h00);
		use_tb_pd <= 1'b1;
		tb_pd <= 8'hB6;
		fdc_out <= 8'hA6;
		fdd_in <= 7'h15;
		printer_not_floppy <= 1'b0;
		apb(1, IDX_FCR, 8'h04);
		apb(1, IDX_DTR, 8'h96);
		apb(1, IDX_CTR, 8'h0A);
		apb(0, IDX_DTR, 8'h00);
		chk(r_data, 8'h96);
		apb(0, IDX_CTR, 8'h00);
		chk(r_data, 8'h0A);
		apb(0, IDX_STR, 8'h00);
		chk(r_data, STS_FLOPPY);
		chk({pd_oe_n, fdc_in}, {8'hFF, 7'h76});
		chk({stat_pin_o, ctl_pin_o[3:1]}, {5'b10110, 3'b100});
		chk(fdd_out, 8'hA6);
		fdc_out <= 8'hA7;
		repeat (3) @(posedge pclk);
		chk(fdc_in, 7'h15);
		printer_not_floppy <= 1'b1;
		fdc_out <= 8'hA6;
		repeat (3) @(posedge pclk);
		chk({stat_pin_oe_n, fdc_in}, {5'h1F, 7'h15});
		apb(1, IDX_FCR, 8'h0C);
		chk({pd_oe_n, ctl_pin_oe_n, stat_pin_oe_n}, 17'h1FFFF);
		apb(0, 4'hB, 8'h00);
		chk(r_err, 1'b1);
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#(100us);
		err_count++;
		stop_test();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, printer_not_floppy} = '0;
		{hold_hi, dly, rd_byte, use_tb_pd, tb_pd, fdc_out, fdd_in, seen_low} = '0;
		err_count = 0;
		compares = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_zws();
		t_rev19();
		t_floppy();
		stop_test();
	end
endmodule // eppm_top_tb_top
